// *** verification/pin_mux_properties.sv ***
`timescale 1ns/1ps
`include "pin_mux_defines.svh"
module pin_mux_properties (
  // Clock, reset, register port
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Pins and peripheral signals
  input wire logic [7:0] port6_pin_oe_n,
  input wire logic [7:0] port6_pin_out,
  input wire logic timer_compare_b_out,
  input wire logic vertical_sync_out,
  input wire logic ext_irq6_in_n,
  input wire logic timer_ext_clock_in
);
  logic [7:0] ctl_q;
  logic [7:0] dir_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Shadow copies of control and direction
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_q <= 8'h00;
      dir_q <= 8'h00;
    end else if (reg_write) begin
      if (reg_addr == `REG_PERIPH_CTRL) ctl_q <= reg_wdata;
      if (reg_addr == `REG_PORT6_DIR) dir_q <= reg_wdata;
    end
  end
  a_pin6_gpio: assert property (
    !ctl_q[0] |-> port6_pin_oe_n[6] == !dir_q[6]) else $error("pin6 dir");
  a_pin6_cmpb: assert property (ctl_q[0] |-> !port6_pin_oe_n[6] &&
    port6_pin_out[6] == timer_compare_b_out) else $error("pin6 cmp b");
  a_pin5_gpio: assert property (
    port6_pin_oe_n[5] == !dir_q[5]) else $error("pin5 dir");
  a_pin1_vsync: assert property (ctl_q[3] |-> !port6_pin_oe_n[1] &&
    port6_pin_out[1] == vertical_sync_out) else $error("pin1 vsync");
  a_irq_gate: assert property (
    !(ctl_q[4] && !ctl_q[5]) |-> ext_irq6_in_n) else $error("irq gate");
  a_clk_gate: assert property (
    ctl_q[7:6] != 2'b11 |-> !timer_ext_clock_in) else $error("clk gate");
  a_rdata_gap: assert property (
    !$past(reg_read) |-> reg_rdata == 8'h00) else $error("rdata idle");
  a_ctrl_read: assert property ($past(reg_read) &&
    $past(reg_addr) == `REG_PERIPH_CTRL |-> reg_rdata == $past(ctl_q))
    else $error("ctrl read");
endmodule

// *** verification/pin_partner.sv ***
`timescale 1ns/1ps
module pin_partner (
  // Port drive and outside level
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] ext_level,
  output logic [7:0] pin_level
);
  // Released pins take the outside level
  assign pin_level = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule

// *** verification/port_six_pin_function_select_tb_top.sv ***
`timescale 1ns/1ps
`include "pin_mux_defines.svh"
module port_six_pin_function_select_tb_top;
  logic core_clk, arst_n, reg_write, reg_read, ca, cb, cl, vs, irq_n, xclk;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, lvl, p6_out, p6_oe_n, pe_oe_n, cmp, rd;
  int bad_count, samples_checked;
  // Rows: control, direction, oe_n, driven value, irq_n, ext clock
  logic [33:0] rows [8] = '{{8'h00, 8'hff, 8'h00, 8'h00, 2'b10},
    {8'h01, 8'h00, 8'hbf, 8'h40, 2'b10}, {8'h02, 8'h00, 8'hfd, 8'h02, 2'b10},
    {8'h08, 8'h00, 8'hfd, 8'h00, 2'b10}, {8'h04, 8'h00, 8'hef, 8'h10, 2'b10},
    {8'h10, 8'h00, 8'hff, 8'h00, 2'b00}, {8'h30, 8'h00, 8'hff, 8'h00, 2'b10},
    {8'hc0, 8'h00, 8'hff, 8'h00, 2'b11}};
  port_six_pin_function_select port_six_pin_function_select_inst (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .port6_pin_in(lvl), .port6_pin_out(p6_out),
    .port6_pin_oe_n(p6_oe_n), .port_e_pin_in(8'h00), .port_e_pin_out(),
    .port_e_pin_oe_n(pe_oe_n), .port_f_pin_in(8'h00), .port_f_pin_out(),
    .port_f_pin_oe_n(), .timer_compare_a_out(ca), .timer_compare_b_out(cb),
    .clamp_out(cl), .vertical_sync_out(vs), .keyboard_in_n(),
    .compare_in(cmp), .ext_irq6_in_n(irq_n), .timer_capture_a_in(),
    .timer_capture_b_in(), .timer_capture_c_in(), .timer_capture_d_in(),
    .timer_ext_clock_in(xclk), .first_timer_clock_in(),
    .second_timer_clock_in(), .vertical_sync_in(), .vertical_feedback_in(),
    .horizontal_feedback_in());
  pin_partner pin_partner_inst (.pin_out(p6_out), .pin_oe_n(p6_oe_n),
    .ext_level(8'h01), .pin_level(lvl));
  // Register bus cycles, one idle cycle after each
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rdr(input logic [3:0] a);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    @(posedge core_clk);
    rd = reg_rdata;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    #20000;
    bad_count++;
    end_sim();
  end
  // Main sequence
  initial begin
    {arst_n, reg_write, reg_read, reg_addr, reg_wdata} = '0;
    {ca, cb, cl, vs, bad_count, samples_checked} = {4'b1110, 64'd0};
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    rdr(`REG_PORT_E_DRIVER_TYPE);
    chk(rd, 8'h00);
    chk(p6_oe_n, 8'hff);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(`REG_PERIPH_CTRL, rows[i][33:26]);
      wr(`REG_PORT6_DIR, rows[i][25:18]);
      repeat (4) @(posedge core_clk);
      chk(p6_oe_n, rows[i][17:10]);
      chk(p6_out & ~p6_oe_n, rows[i][9:2]);
      chk(cmp, lvl);
      chk({7'h00, irq_n}, {7'h00, rows[i][1]});
      chk({7'h00, xclk}, {7'h00, rows[i][0]});
      $display("test row %0d done", i);
    end
    wr(`REG_PERIPH_CTRL, 8'h0a);
    chk(p6_out & ~p6_oe_n, 8'h00);
    chk(p6_oe_n, 8'hfd);
    wr(`REG_PORT_E_DIR, 8'hff);
    wr(`REG_PORT_E_DATA, 8'h0f);
    wr(`REG_PORT_E_DRIVER_TYPE, 8'h05);
    chk(pe_oe_n, 8'h05);
    wr(`REG_PORT_E_DIR, 8'h0f);
    chk(pe_oe_n, 8'hf5);
    rdr(4'hf);
    chk(rd, 8'h00);
    arst_n <= 1'b0;
    @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    rdr(`REG_PERIPH_CTRL);
    chk(rd, 8'h00);
    $display("test awkward done");
    end_sim();
  end
endmodule
bind port_six_pin_function_select pin_mux_properties pin_mux_properties_inst (
  .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .port6_pin_oe_n(port6_pin_oe_n),
  .port6_pin_out(port6_pin_out), .timer_compare_b_out(timer_compare_b_out),
  .vertical_sync_out(vertical_sync_out), .ext_irq6_in_n(ext_irq6_in_n),
  .timer_ext_clock_in(timer_ext_clock_in));

// *** verilog/pin_mux_defines.svh ***
`ifndef PIN_MUX_DEFINES_SVH
`define PIN_MUX_DEFINES_SVH

// Register indices on the plain register port
`define REG_PORT6_DATA 4'h0
`define REG_PORT6_DIR 4'h1
`define REG_PERIPH_CTRL 4'h2
`define REG_PORT6_PIN 4'h3
`define REG_PORT_E_DRIVER_TYPE 4'h4
`define REG_PORT_F_DRIVER_TYPE 4'h5
`define REG_PORT_E_DATA 4'h6
`define REG_PORT_E_DIR 4'h7
`define REG_PORT_F_DATA 4'h8
`define REG_PORT_F_DIR 4'h9

// Peripheral control field positions
`define CTL_TIMER_OUT_B_ENABLE 0
`define CTL_TIMER_OUT_A_ENABLE 1
`define CTL_CLAMP_OUTPUT_ENABLE 2
`define CTL_VSYNC_OUTPUT_ENABLE 3
`define CTL_EXT_IRQ6_ENABLE 4
`define CTL_KEYBOARD_MASK_BIT6 5
`define CTL_CLOCK_SELECT_LO 6
`define CTL_CLOCK_SELECT_HI 7

// Reset values
`define RESET_BYTE 8'h00

`endif

// *** verilog/pin_mux_pkg.sv ***
package pin_mux_pkg;

  typedef logic [7:0] byte_t;

  // Register-bank state of the pin mux
  typedef struct packed {
    byte_t port6_data;
    byte_t port6_dir;
    byte_t periph_ctrl;
    byte_t port_e_driver_type;
    byte_t port_f_driver_type;
    byte_t port_e_data;
    byte_t port_e_dir;
    byte_t port_f_data;
    byte_t port_f_dir;
    byte_t rdata;
    byte_t pin_s2;
    byte_t pin_s3;
    byte_t pin_stable;
  } pin_mux_state_s;

endpackage

// *** verilog/port_six_pin_function_select.sv ***
`timescale 1ns/1ps
`include "pin_mux_defines.svh"

module port_six_pin_function_select (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Port six pins
  input wire logic [7:0] port6_pin_in,
  output logic [7:0] port6_pin_out,
  output logic [7:0] port6_pin_oe_n,
  // Port E and port F pins, open-drain capable
  input wire logic [7:0] port_e_pin_in,
  output logic [7:0] port_e_pin_out,
  output logic [7:0] port_e_pin_oe_n,
  input wire logic [7:0] port_f_pin_in,
  output logic [7:0] port_f_pin_out,
  output logic [7:0] port_f_pin_oe_n,
  // Peripheral outputs steered onto port six
  input wire logic timer_compare_a_out,
  input wire logic timer_compare_b_out,
  input wire logic clamp_out,
  input wire logic vertical_sync_out,
  // Peripheral inputs taken from port six
  output logic [7:0] keyboard_in_n,
  output logic [7:0] compare_in,
  output logic ext_irq6_in_n,
  output logic timer_capture_a_in,
  output logic timer_capture_b_in,
  output logic timer_capture_c_in,
  output logic timer_capture_d_in,
  output logic timer_ext_clock_in,
  output logic first_timer_clock_in,
  output logic second_timer_clock_in,
  output logic vertical_sync_in,
  output logic vertical_feedback_in,
  output logic horizontal_feedback_in
);

  pin_mux_pkg::pin_mux_state_s s_q;
  pin_mux_pkg::pin_mux_state_s s_d;

  logic timer_out_b_enable;
  logic timer_out_a_enable;
  logic clamp_output_enable;
  logic vsync_output_enable;
  logic ext_irq6_enable;
  logic keyboard_mask_bit6;
  logic timer_clock_select_hi;
  logic timer_clock_select_lo;
  logic [7:0] drive_en;
  logic [7:0] drive_val;
  logic [7:0] pin_s1_q;

  // Driver-type mapping for an open-drain capable port
  function automatic logic [7:0] od_oe_n(input logic [7:0] dir,
                                         input logic [7:0] nch,
                                         input logic [7:0] val);
    od_oe_n = ~(dir & ~(nch & val));
  endfunction

  // Control field decode
  assign timer_out_b_enable = s_q.periph_ctrl[`CTL_TIMER_OUT_B_ENABLE];
  assign timer_out_a_enable = s_q.periph_ctrl[`CTL_TIMER_OUT_A_ENABLE];
  assign clamp_output_enable = s_q.periph_ctrl[`CTL_CLAMP_OUTPUT_ENABLE];
  assign vsync_output_enable = s_q.periph_ctrl[`CTL_VSYNC_OUTPUT_ENABLE];
  assign ext_irq6_enable = s_q.periph_ctrl[`CTL_EXT_IRQ6_ENABLE];
  assign keyboard_mask_bit6 = s_q.periph_ctrl[`CTL_KEYBOARD_MASK_BIT6];
  assign timer_clock_select_lo = s_q.periph_ctrl[`CTL_CLOCK_SELECT_LO];
  assign timer_clock_select_hi = s_q.periph_ctrl[`CTL_CLOCK_SELECT_HI];

  // Port six output selection per pin
  always_comb begin
    drive_en = s_q.port6_dir;
    drive_val = s_q.port6_data;
    if (timer_out_b_enable) begin
      drive_en[6] = 1'b1;
      drive_val[6] = timer_compare_b_out;
    end else begin
      drive_en[6] = s_q.port6_dir[6];
    end
    if (clamp_output_enable) begin
      drive_en[4] = 1'b1;
      drive_val[4] = clamp_out;
    end else begin
      drive_en[4] = s_q.port6_dir[4];
    end
    if (vsync_output_enable) begin
      drive_en[1] = 1'b1;
      drive_val[1] = vertical_sync_out;
    end else if (timer_out_a_enable) begin
      drive_en[1] = 1'b1;
      drive_val[1] = timer_compare_a_out;
    end
  end

  // Pin drivers
  assign port6_pin_out = drive_val;
  assign port6_pin_oe_n = ~drive_en;
  assign port_e_pin_out = s_q.port_e_data;
  assign port_f_pin_out = s_q.port_f_data;
  assign port_e_pin_oe_n = od_oe_n(s_q.port_e_dir, s_q.port_e_driver_type,
                                   s_q.port_e_data);
  assign port_f_pin_oe_n = od_oe_n(s_q.port_f_dir, s_q.port_f_driver_type,
                                   s_q.port_f_data);

  // Peripheral inputs from the filtered pin levels
  assign keyboard_in_n = s_q.pin_stable;
  assign compare_in = s_q.pin_stable;
  assign ext_irq6_in_n = (ext_irq6_enable && !keyboard_mask_bit6) ?
                         s_q.pin_stable[6] : 1'b1;
  assign timer_capture_d_in = s_q.pin_stable[5];
  assign timer_capture_c_in = s_q.pin_stable[4];
  assign timer_capture_b_in = s_q.pin_stable[3];
  assign vertical_feedback_in = s_q.pin_stable[3];
  assign timer_capture_a_in = s_q.pin_stable[2];
  assign vertical_sync_in = s_q.pin_stable[2];
  assign second_timer_clock_in = s_q.pin_stable[2];
  assign timer_ext_clock_in = (timer_clock_select_hi &&
                               timer_clock_select_lo) ?
                              s_q.pin_stable[0] : 1'b0;
  assign first_timer_clock_in = s_q.pin_stable[0];
  assign horizontal_feedback_in = s_q.pin_stable[0];
  assign reg_rdata = s_q.rdata;

  // Register writes, reads and pin synchroniser
  always_comb begin
    s_d = s_q;
    s_d.pin_s2 = pin_s1_q;
    s_d.pin_s3 = s_q.pin_s2;
    for (int i = 0; i < 8; i++) begin
      if (s_q.pin_s2[i] == s_q.pin_s3[i]) begin
        s_d.pin_stable[i] = s_q.pin_s3[i];
      end
    end
    if (reg_write) begin
      case (reg_addr)
        `REG_PORT6_DATA: s_d.port6_data = reg_wdata;
        `REG_PORT6_DIR: s_d.port6_dir = reg_wdata;
        `REG_PERIPH_CTRL: s_d.periph_ctrl = reg_wdata;
        `REG_PORT_E_DRIVER_TYPE: s_d.port_e_driver_type = reg_wdata;
        `REG_PORT_F_DRIVER_TYPE: s_d.port_f_driver_type = reg_wdata;
        `REG_PORT_E_DATA: s_d.port_e_data = reg_wdata;
        `REG_PORT_E_DIR: s_d.port_e_dir = reg_wdata;
        `REG_PORT_F_DATA: s_d.port_f_data = reg_wdata;
        `REG_PORT_F_DIR: s_d.port_f_dir = reg_wdata;
        default: begin
        end
      endcase
    end
    s_d.rdata = `RESET_BYTE;
    if (reg_read) begin
      case (reg_addr)
        `REG_PORT6_DATA: s_d.rdata = s_q.port6_data;
        `REG_PORT6_DIR: s_d.rdata = s_q.port6_dir;
        `REG_PERIPH_CTRL: s_d.rdata = s_q.periph_ctrl;
        `REG_PORT6_PIN: s_d.rdata = s_q.pin_stable;
        `REG_PORT_E_DRIVER_TYPE: s_d.rdata = s_q.port_e_driver_type;
        `REG_PORT_F_DRIVER_TYPE: s_d.rdata = s_q.port_f_driver_type;
        `REG_PORT_E_DATA: s_d.rdata = s_q.port_e_data;
        `REG_PORT_E_DIR: s_d.rdata = s_q.port_e_dir;
        `REG_PORT_F_DATA: s_d.rdata = s_q.port_f_data;
        `REG_PORT_F_DIR: s_d.rdata = s_q.port_f_dir;
        default: s_d.rdata = `RESET_BYTE;
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // First synchroniser stage, read only by the second
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_q <= `RESET_BYTE;
    end else begin
      pin_s1_q <= port6_pin_in;
    end
  end

endmodule
